// *** core/bcr_board_regs.sv ***
// Board control and status register bank with watchdog and reset routing.
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module bcr_board_regs
  import bcr_pkg::*;
#(
  parameter int                              TICK_CYCLES = WD_TICK_CYCLES,
  parameter logic [bcr_pkg::REV_IDX_W-1:0]   HW_REV      = 4'h0,
  parameter logic [bcr_pkg::REV_IDX_W-1:0]   LOGIC_REV   = 4'h0
) (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bcr_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [bcr_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [bcr_pkg::STRB_W-1:0]    pstrb,
  output logic      [bcr_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [bcr_pkg::SLOT_ADDR_W-1:0] slot_address,
  input  wire logic                          system_slot,
  input  wire logic                          bp_reset_n_in,
  output logic                               bp_reset_n_out,
  output logic                               bp_reset_n_oe,
  input  wire logic                          front_panel_reset_n,
  input  wire logic                          misc_reset,
  input  wire logic                          bp_reset_disable,
  input  wire logic                          local_reset_n,
  output logic                               local_reset_req_n,
  output logic                               wd_expired
);

  //////////////////////////////////////////////////////////////////////////
  // Register addresses.

  localparam logic [ADDR_W-1:0] ADDR_GEO  = {IDX_GEO_ADDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_REV  = {IDX_REVISION, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WD   = {IDX_WD_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RST  = {IDX_RST_STATUS, 2'b00};

  // Everything this bank remembers, apart from u_sync and u_wd, sits in one record. The read data
  // register is part of it, so prdata comes straight from a flop.
  typedef struct packed {
    logic [DATA_W-1:0]   prdata;
    logic                wd_enable_retrigger;
    logic [WD_SEL_W-1:0] wd_timeout_select;
    logic [REG_W-1:0]    reset_source_status;
    logic                local_req_n;
    logic                bp_out_n;
  } bcr_top_st_t;

  bcr_top_st_t s_ff;
  bcr_top_st_t nxt_s;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  // Every pin takes the same two flops, so pins that move together are
  // seen together. The reset value of the vector is each pin's idle
  // level, so no false event follows reset.
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;

  always_comb begin
    pins_raw = '0;
    pins_raw[PIN_GA_LSB +: SLOT_ADDR_W] = slot_address;
    pins_raw[PIN_SYS_SLOT]  = system_slot;
    pins_raw[PIN_BP_RST_N]  = bp_reset_n_in;
    pins_raw[PIN_FP_RST_N]  = front_panel_reset_n;
    pins_raw[PIN_MISC_RST]  = misc_reset;
    pins_raw[PIN_BP_DIS]    = bp_reset_disable;
    pins_raw[PIN_LOC_RST_N] = local_reset_n;
  end

  bcr_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RESET)
  ) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  (pins_raw),
    .dout (pins)
  );

  logic [SLOT_ADDR_W-1:0] ga_s;
  logic                   sys_slot_s;
  logic                   bp_rst_s;
  logic                   fp_rst_s;
  logic                   misc_rst_s;
  logic                   bp_dis_s;
  logic                   loc_rst_s;

  assign ga_s       = pins[PIN_GA_LSB +: SLOT_ADDR_W];
  assign sys_slot_s = pins[PIN_SYS_SLOT];
  assign bp_rst_s   = !pins[PIN_BP_RST_N];
  assign fp_rst_s   = !pins[PIN_FP_RST_N];
  assign misc_rst_s = pins[PIN_MISC_RST];
  assign bp_dis_s   = pins[PIN_BP_DIS];
  assign loc_rst_s  = !pins[PIN_LOC_RST_N];

  //////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic addr_hit;
  logic hit_geo;
  logic hit_rev;
  logic hit_wd;
  logic hit_rst;
  logic setup_ph;
  logic access_ph;
  logic wr_lane0;
  logic wr_wd;
  logic wr_rst;

  // Only whole aligned words hit; a byte offset inside a word is refused.
  assign hit_geo  = (paddr == ADDR_GEO);
  assign hit_rev  = (paddr == ADDR_REV);
  assign hit_wd   = (paddr == ADDR_WD);
  assign hit_rst  = (paddr == ADDR_RST);
  assign addr_hit = hit_geo || hit_rev || hit_wd || hit_rst;

  // Zero-wait slave: read data is captured in the setup cycle so that
  // it comes from a flop while pready can stay high.
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !addr_hit;
  // Registers sit in byte lane 0; writes with that lane off are dropped.
  assign wr_lane0  = access_ph && pwrite && pstrb[0];
  assign wr_wd     = wr_lane0 && hit_wd;
  assign wr_rst    = wr_lane0 && hit_rst;

  //////////////////////////////////////////////////////////////////////////
  // Watchdog.

  logic                wd_reload;
  logic                wd_fire;
  logic [WD_SEL_W-1:0] wd_sel_now;

  // The retrigger pulse also serves as the first enable load.
  assign wd_reload = wr_wd && pwdata[WD_EN_BIT];

  // A load takes the period written with it, not the one it replaces, so
  // enabling and choosing the timeout can share one write.
  always_comb begin
    wd_sel_now = s_ff.wd_timeout_select;
    if (wr_wd) begin
      wd_sel_now = pwdata[WD_SEL_W-1:0];
    end
  end

  // The timer keeps counting after it fires; what an expiry does beyond
  // the status flag is left to logic outside this bank.
  bcr_wd_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wd (
    .mclk   (mclk),
    .nrst   (nrst),
    .enable (s_ff.wd_enable_retrigger),
    .reload (wd_reload),
    .sel    (wd_sel_now),
    .expire (wd_fire)
  );

  assign wd_expired = wd_fire;

  //////////////////////////////////////////////////////////////////////////
  // Reset routing and status.

  logic             bp_routed;
  logic [REG_W-1:0] rst_set;
  logic [REG_W-1:0] rst_clr;
  logic [REG_W-1:0] rst_next;

  // Slot kind is meant to be fixed from power-up; a board that changes it
  // while running may take the tail of its own driven line as a reset.
  // Handling counts as disabled while the control bit is set.
  assign bp_routed = !sys_slot_s && bp_rst_s
                     && !s_ff.reset_source_status[RST_CTRL_BIT];

  always_comb begin
    rst_set               = '0;
    rst_set[RST_WD_BIT]   = wd_fire;
    rst_set[RST_BP_BIT]   = bp_routed;
    rst_set[RST_FP_BIT]   = fp_rst_s;
    rst_set[RST_MISC_BIT] = misc_rst_s;
    rst_set[RST_CTRL_BIT] = bp_dis_s;
    rst_clr               = '0;
    if (wr_rst) begin
      rst_clr = pwdata[REG_W-1:0] & RST_W1C_MASK;
    end
  end

  // One flag cell per bit. Set wins over clear so that an event in the
  // clearing cycle survives, and bit 1 has no clear at all.
  generate
    for (genvar b = 0; b < REG_W; b++) begin : g_flag
      assign rst_next[b] = (s_ff.reset_source_status[b] && !rst_clr[b])
                           || rst_set[b];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [REG_W-1:0] geo_byte;
  logic [REG_W-1:0] rev_byte;
  logic [REG_W-1:0] wd_byte;
  logic [REG_W-1:0] rst_byte;
  logic [REG_W-1:0] rd_byte;

  // Reserved bits of every register read as zero; writes to the
  // read-only bytes are dropped without an error.
  always_comb begin
    geo_byte                  = '0;
    geo_byte[SLOT_ADDR_W-1:0] = ga_s;
    rev_byte                  = {HW_REV, LOGIC_REV};
    wd_byte                   = '0;
    wd_byte[WD_EN_BIT]        = s_ff.wd_enable_retrigger;
    wd_byte[WD_SEL_W-1:0]     = s_ff.wd_timeout_select;
    rst_byte                  = s_ff.reset_source_status;
  end

  // Unmapped addresses read zero as well as raising the error.
  always_comb begin
    rd_byte = '0;
    if (hit_geo) begin
      rd_byte = geo_byte;
    end
    if (hit_rev) begin
      rd_byte = rev_byte;
    end
    if (hit_wd) begin
      rd_byte = wd_byte;
    end
    if (hit_rst) begin
      rd_byte = rst_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_s = s_ff;
    // A write's setup cycle clears prdata, so stale read data never lingers.
    if (setup_ph) begin
      nxt_s.prdata = RDATA_ZERO;
      if (!pwrite) begin
        nxt_s.prdata[REG_W-1:0] = rd_byte;
      end
    end
    if (wr_wd) begin
      nxt_s.wd_timeout_select = pwdata[WD_SEL_W-1:0];
      // Sticky: a written 0 never turns the watchdog off.
      if (pwdata[WD_EN_BIT]) begin
        nxt_s.wd_enable_retrigger = 1'b1;
      end
    end
    nxt_s.reset_source_status = rst_next;
    nxt_s.local_req_n = !bp_routed;
    nxt_s.bp_out_n    = !loc_rst_s;
  end

  // Backplane reset never reaches nrst, so the status survives it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff.prdata              <= RDATA_ZERO;
      s_ff.wd_enable_retrigger <= 1'b0;
      s_ff.wd_timeout_select   <= WD_SEL_RESET;
      s_ff.reset_source_status <= RST_STATUS_RESET;
      s_ff.local_req_n         <= 1'b1;
      s_ff.bp_out_n            <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata            = s_ff.prdata;
  assign local_reset_req_n = s_ff.local_req_n;
  assign bp_reset_n_out    = s_ff.bp_out_n;
  // The backplane line is driven only from a system slot.
  assign bp_reset_n_oe     = sys_slot_s;

endmodule : bcr_board_regs
`default_nettype wire

// *** core/bcr_pkg.sv ***
// Constants, register map and timeout ladder shared by the board control registers.
`default_nettype none
package bcr_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          WD_TICK_NS     = 1000000;
  localparam int          WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;
  localparam int          TICK_W         = 17;
  localparam int          WD_CNT_W       = 18;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 8;
  localparam int          IDX_W          = 10;
  localparam int          STRB_W         = DATA_W / 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_GEO_ADDR   = 10'h282;
  localparam logic [IDX_W-1:0] IDX_REVISION   = 10'h283;
  localparam logic [IDX_W-1:0] IDX_WD_CTRL    = 10'h284;
  localparam logic [IDX_W-1:0] IDX_RST_STATUS = 10'h285;

  localparam int          WD_EN_BIT      = 4;
  localparam int          WD_SEL_W       = 4;
  localparam int          SLOT_ADDR_W    = 5;
  localparam int          REV_IDX_W      = 4;
  localparam int          RST_WD_BIT     = 0;
  localparam int          RST_BP_BIT     = 1;
  localparam int          RST_FP_BIT     = 2;
  localparam int          RST_MISC_BIT   = 3;
  localparam int          RST_CTRL_BIT   = 7;

  localparam logic [REG_W-1:0]    RST_STATUS_RESET = 8'h00;
  localparam logic [REG_W-1:0]    RST_W1C_MASK     = 8'h8d;
  localparam logic [WD_SEL_W-1:0] WD_SEL_RESET     = 4'h0;
  localparam logic [DATA_W-1:0]   RDATA_ZERO       = 32'h0;

  // Pin vector layout at the synchroniser.
  localparam int          PIN_GA_LSB     = 0;
  localparam int          PIN_SYS_SLOT   = 5;
  localparam int          PIN_BP_RST_N   = 6;
  localparam int          PIN_FP_RST_N   = 7;
  localparam int          PIN_MISC_RST   = 8;
  localparam int          PIN_BP_DIS     = 9;
  localparam int          PIN_LOC_RST_N  = 10;
  localparam int          PIN_W          = 11;
  localparam logic [PIN_W-1:0] PIN_RESET   = 11'h4c0;

  // Timeout ladder in milliseconds; reserved codes take the longest period.
  function automatic logic [WD_CNT_W-1:0] wd_timeout_ms(
    input logic [WD_SEL_W-1:0] sel
  );
    case (sel)
      4'h0:    wd_timeout_ms = 18'h0007d;
      4'h1:    wd_timeout_ms = 18'h000fa;
      4'h2:    wd_timeout_ms = 18'h001f4;
      4'h3:    wd_timeout_ms = 18'h003e8;
      4'h4:    wd_timeout_ms = 18'h007d0;
      4'h5:    wd_timeout_ms = 18'h00fa0;
      4'h6:    wd_timeout_ms = 18'h01f40;
      4'h7:    wd_timeout_ms = 18'h03e80;
      4'h8:    wd_timeout_ms = 18'h07d00;
      4'h9:    wd_timeout_ms = 18'h0fa00;
      4'ha:    wd_timeout_ms = 18'h1f400;
      default: wd_timeout_ms = 18'h3e800;
    endcase
  endfunction : wd_timeout_ms
endpackage : bcr_pkg
`default_nettype wire

// *** core/bcr_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels.
`default_nettype none
module bcr_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic [W-1:0]   din,
  output logic      [W-1:0]   dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bcr_sync_st_t;

  bcr_sync_st_t s_ff;
  bcr_sync_st_t nxt_s;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_s.meta   = din;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= {RST_VAL, RST_VAL};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.stable;
endmodule : bcr_sync
`default_nettype wire

// *** core/bcr_wd_timer.sv ***
// Watchdog countdown with a millisecond tick divider.
`default_nettype none
module bcr_wd_timer
  import bcr_pkg::*;
#(
  parameter int                         TICK_CYCLES = WD_TICK_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  input  wire logic                     enable,
  input  wire logic                     reload,
  input  wire logic [bcr_pkg::WD_SEL_W-1:0] sel,
  output logic                          expire
);
  typedef struct packed {
    logic [TICK_W-1:0]   tick;
    logic [WD_CNT_W-1:0] ms;
    logic                expire;
  } bcr_wd_st_t;

  localparam logic [TICK_W-1:0]   TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [WD_CNT_W-1:0] MS_LAST   = 18'h00001;

  bcr_wd_st_t s_ff;
  bcr_wd_st_t nxt_s;

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.expire = 1'b0;
    if (!enable || reload) begin
      // Preloading while idle makes the first enable start a full period.
      nxt_s.tick = '0;
      nxt_s.ms   = wd_timeout_ms(sel);
    end else if (s_ff.tick == TICK_LAST) begin
      nxt_s.tick = '0;
      if (s_ff.ms <= MS_LAST) begin
        nxt_s.expire = 1'b1;
        nxt_s.ms     = wd_timeout_ms(sel);
      end else begin
        nxt_s.ms = s_ff.ms - MS_LAST;
      end
    end else begin
      nxt_s.tick = s_ff.tick + TICK_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign expire = s_ff.expire;
endmodule : bcr_wd_timer
`default_nettype wire

// *** verif/bcr_bp_model.sv ***
// Backplane side: slot address pins, slot kind and the shared reset line.
`default_nettype none
module bcr_bp_model (
  input  wire logic       mclk,
  input  wire logic [4:0] ga_set,
  input  wire logic       sys_set,
  input  wire logic       rst_set,
  input  wire logic       bp_reset_n_oe,
  input  wire logic       bp_reset_n_out,
  output var  logic [4:0] slot_address,
  output var  logic       system_slot,
  output var  logic       bp_reset_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    slot_address  = 5'h0;
    system_slot   = 1'b0;
    bp_reset_n_in = 1'b1;
  end
  // The reset line has a pull-up, so it idles high when nobody pulls it.
  always @(posedge mclk) begin
    slot_address  <= ga_set;
    system_slot   <= sys_set;
    bp_reset_n_in <= bp_reset_n_oe ? bp_reset_n_out : !rst_set;
  end
endmodule : bcr_bp_model
`default_nettype wire

// *** verif/bcr_regs_assertions.sv ***
// Port-level assertions for the board register bank.
`default_nettype none
module bcr_regs_chk
  import bcr_pkg::*;
#(
  parameter logic [3:0] HW_REV    = 4'h0,
  parameter logic [3:0] LOGIC_REV = 4'h0
) (
  input wire logic                       mclk,
  input wire logic                       nrst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [bcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [bcr_pkg::DATA_W-1:0] pwdata,
  input wire logic [bcr_pkg::STRB_W-1:0] pstrb,
  input wire logic [bcr_pkg::DATA_W-1:0] prdata,
  input wire logic                       system_slot,
  input wire logic                       bp_reset_n_out,
  input wire logic                       bp_reset_n_oe,
  input wire logic                       bp_reset_disable,
  input wire logic                       local_reset_n,
  input wire logic                       local_reset_req_n
);
  logic [2:0] age_ff;
  logic       wd_on_ff;
  logic       acc;
  assign acc = psel && penable;
  // The age count keeps pin checks off the synchroniser's reset values.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      age_ff   <= 3'h0;
      wd_on_ff <= 1'b0;
    end else begin
      age_ff   <= (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
      wd_on_ff <= wd_on_ff | (acc & pwrite & pstrb[0] & pwdata[4] &
                              (paddr == 12'ha10));
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence s_up;
    age_ff == 3'h7;
  endsequence
  property p_wd_off;
    s_rd(12'ha10) ##0 !wd_on_ff |-> !prdata[4];
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("enable set early");
  property p_wd_on;
    s_rd(12'ha10) ##0 wd_on_ff |-> prdata[4];
  endproperty
  a_wd_on: assert property (p_wd_on) else $error("enable lost");
  property p_geo;
    s_rd(12'ha08) |-> prdata[31:5] == 27'h0;
  endproperty
  a_geo: assert property (p_geo) else $error("slot upper bits");
  property p_rev;
    s_rd(12'ha0c) |-> prdata == {24'h0, HW_REV, LOGIC_REV};
  endproperty
  a_rev: assert property (p_rev) else $error("revision value");
  property p_oe;
    s_up ##0 $stable(system_slot)[*3] |-> bp_reset_n_oe == system_slot;
  endproperty
  a_oe: assert property (p_oe) else $error("reset drive enable");
  property p_bp_out;
    s_up ##0 (!local_reset_n)[*4] |-> !bp_reset_n_out;
  endproperty
  a_bp_out: assert property (p_bp_out) else $error("reset not driven");
  property p_no_req;
    s_up ##0 system_slot[*4] |-> local_reset_req_n;
  endproperty
  a_no_req: assert property (p_no_req) else $error("system slot req");
  property p_ignore;
    s_up ##0 bp_reset_disable[*6] |-> local_reset_req_n;
  endproperty
  a_ignore: assert property (p_ignore) else $error("reset not ignored");
endmodule : bcr_regs_chk

bind bcr_board_regs bcr_regs_chk #(.HW_REV(HW_REV), .LOGIC_REV(LOGIC_REV))
  u_chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .system_slot, .bp_reset_n_out, .bp_reset_n_oe, .bp_reset_disable,
  .local_reset_n, .local_reset_req_n);
`default_nettype wire

// *** verif/test_board_control_status_registers.sv ***
// Self-checking bench for the board register bank.
`default_nettype none
module test_board_control_status_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, front_panel_reset_n = 1'b1, misc_reset = 1'b0;
  logic        sys_set = 1'b0, rst_set = 1'b0, bp_reset_disable = 1'b0;
  logic        local_reset_n = 1'b1, err, pready, pslverr, system_slot;
  logic        bp_reset_n_in, bp_reset_n_out, bp_reset_n_oe;
  logic        local_reset_req_n, wd_expired;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h1;
  logic [4:0]  ga_set = 5'h0, slot_address;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  bcr_board_regs #(.TICK_CYCLES(4), .HW_REV(4'h3), .LOGIC_REV(4'h1)) dut (
    .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .slot_address, .system_slot, .bp_reset_n_in,
    .bp_reset_n_out, .bp_reset_n_oe, .front_panel_reset_n, .misc_reset,
    .bp_reset_disable, .local_reset_n, .local_reset_req_n, .wd_expired);
  bcr_bp_model bp (.mclk, .ga_set, .sys_set, .rst_set, .bp_reset_n_oe,
    .bp_reset_n_out, .slot_address, .system_slot, .bp_reset_n_in);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  // Holds the request until pready; one idle edge keeps strobes clean.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk
  task automatic pins(input logic [2:0] e);
    @(negedge mclk);
    check({29'h0, bp_reset_n_oe, bp_reset_n_out, local_reset_req_n},
          {29'h0, e});
    @(posedge mclk);
  endtask : pins
  task automatic t_regs;
    ga_set <= 5'h15;
    rdchk(12'ha14, 32'h0);
    front_panel_reset_n <= 1'b0;
    misc_reset <= 1'b1;
    cyc(4);
    front_panel_reset_n <= 1'b1;
    misc_reset <= 1'b0;
    apb(1'b1, 12'ha08, 32'hff);
    rdchk(12'ha08, 32'h15);
    rdchk(12'ha0c, 32'h31);
    rdchk(12'ha14, 32'h0c);
    apb(1'b1, 12'ha14, 32'h0);
    rdchk(12'ha14, 32'h0c);
    apb(1'b1, 12'ha14, 32'h04);
    rdchk(12'ha14, 32'h08);
    apb(1'b0, 12'ha11, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
  endtask : t_regs
  task automatic t_route;
    pins(3'b011);
    rst_set <= 1'b1;
    cyc(5);
    pins(3'b010);
    rst_set <= 1'b0;
    cyc(5);
    rdchk(12'ha14, 32'h0a);
    bp_reset_disable <= 1'b1;
    cyc(8);
    bp_reset_disable <= 1'b0;
    rst_set <= 1'b1;
    cyc(5);
    pins(3'b011);
    rst_set <= 1'b0;
    cyc(5);
    apb(1'b1, 12'ha14, 32'hff);
    rdchk(12'ha14, 32'h02);
    sys_set <= 1'b1;
    local_reset_n <= 1'b0;
    cyc(6);
    pins(3'b101);
    sys_set <= 1'b0;
    local_reset_n <= 1'b1;
    cyc(6);
  endtask : t_route
  task automatic wd_wait(output int n);
    n = 0;
    while (wd_expired !== 1'b1 && n < 1200) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask : wd_wait
  // A retrigger late in the first period must push expiry a full period out.
  task automatic t_wd;
    int n;
    rdchk(12'ha10, 32'h0);
    apb(1'b1, 12'ha10, 32'h11);
    rdchk(12'ha10, 32'h11);
    apb(1'b1, 12'ha10, 32'h01);
    rdchk(12'ha10, 32'h11);
    cyc(700);
    rdchk(12'ha14, 32'h02);
    apb(1'b1, 12'ha10, 32'h11);
    wd_wait(n);
    check(32'(n > 985 && n < 1006), 32'h1);
    rdchk(12'ha14, 32'h03);
    apb(1'b1, 12'ha14, 32'h01);
    rdchk(12'ha14, 32'h02);
    apb(1'b1, 12'ha10, 32'h10);
    wd_wait(n);
    check(32'(n > 485 && n < 506), 32'h1);
    rdchk(12'ha10, 32'h10);
  endtask : t_wd
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    cyc(4);
    nrst <= 1'b1;
    cyc(1);
    t_regs();
    t_route();
    t_wd();
    stop_test();
  end
endmodule : test_board_control_status_registers
`default_nettype wire
